// ==== rtl/clkdiv_consts.svh ====
// Register indices, field positions, reset values and ratio limits of the clock divider block.
`ifndef CLKDIV_CONSTS_SVH
`define CLKDIV_CONSTS_SVH

// ********
// Register indices (byte address is four times the index)
// ********
`define IDX_SECOND_LOW 8'h3D
`define IDX_ANALOG_NM 8'h3E
`define IDX_CORE_EN 8'h44
`define IDX_PORT_EN 8'h45
`define IDX_CLKOUT_SRC 8'h46
`define IDX_CLOCK_OUTPUT_RATIO 8'h47
`define IDX_SECOND_HIGH 8'h60
`define IDX_CONTROL 8'h61
`define IDX_STATUS 8'h62

// ********
// Reset values
// ********
`define RST_SECOND_LOW 8'h01
`define RST_SECOND_HIGH 1'h0
`define RST_ANALOG_NM 6'h01
`define RST_CORE_EN 3'h0
`define RST_PORT_EN 8'h00
`define RST_CLKOUT_SRC 3'h0
`define RST_CLOCK_OUTPUT_RATIO 8'h01
`define RST_CONTROL 1'h0

// ********
// Field positions
// ********
`define BIT_N_EN 2
`define BIT_M_EN 1
`define BIT_PDM_EN 0
`define BIT_MOD_EN 4
`define BIT_FIRST_BCLK_EN 3
`define BIT_SECOND_BCLK_EN 2
`define BIT_FIRST_FS_EN 1
`define BIT_SECOND_FS_EN 0
`define BIT_CLKOUT_EN 7
`define MSB_CLKOUT_RATIO 6

// ********
// Ratio decoding for a zero code and source selector codes
// ********
`define ZERO_RATIO_SECOND 10'h200
`define ZERO_RATIO_ANALOG 10'h040
`define ZERO_RATIO_CLKOUT 10'h080
`define SRC_PLL 3'h0
`define SRC_FIRST_BCLK 3'h1
`define SRC_SECOND_BCLK 3'h2
`define SRC_CONTROL 3'h3
`define SRC_OSC 3'h4
`define SRC_DSP 3'h5
`define NUM_DIVIDERS 10

`endif

// ==== rtl/clkdiv_pkg.sv ====
// Types shared by the clock divider block.
package clkdiv_pkg;

    typedef enum {
        SEL_NONE,
        SEL_SECOND_LOW,
        SEL_ANALOG_NM,
        SEL_CORE_EN,
        SEL_PORT_EN,
        SEL_CLKOUT_SRC,
        SEL_CLOCK_OUTPUT_RATIO,
        SEL_SECOND_HIGH,
        SEL_CONTROL,
        SEL_STATUS
    } reg_sel_t;

    typedef struct packed {
        logic [7:0] second_low;
        logic second_high;
        logic [5:0] analog_ratio;
        logic [2:0] core_en;
        logic [7:0] port_en;
        logic [2:0] clkout_sel;
        logic [7:0] clock_output_ratio;
        logic auto_detect;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } regs_t;

endpackage : clkdiv_pkg

// ==== rtl/ratio_divider.sv ====
// One gated divider that counts rising edges of a sampled source clock.
`timescale 1ns/1ps
module ratio_divider #(
    parameter int RATIO_W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic enable,
    input wire logic [RATIO_W-1:0] ratio,
    // Source and divided clock
    input wire logic source,
    output logic div_clk
);

    typedef struct packed {
        logic [RATIO_W-1:0] cnt;
        logic src_q;
        logic div_clk;
    } div_state_t;

    div_state_t state;
    div_state_t next_state;
    logic [RATIO_W-1:0] last;
    logic [RATIO_W-1:0] half;

    if (RATIO_W < 2) begin : g_bad_width
        $error("ratio_divider needs a ratio width of at least 2");
    end

    assign last = ratio - RATIO_W'(1);
    assign half = ratio >> 1;

    always_comb begin
        next_state = state;
        next_state.src_q = source;
        if (!enable) begin
            // A stopped divider parks low with a cleared count so it restarts cleanly.
            next_state.cnt = '0; // R18
            next_state.div_clk = 1'b0; // R18
        end else if (ratio == RATIO_W'(1)) begin
            next_state.cnt = '0;
            next_state.div_clk = source; // R17
        end else if (source && !state.src_q) begin
            // A count beyond the ratio after a reprogram reloads to zero on the next source rising edge.
            if (state.cnt >= last) begin
                next_state.cnt = '0; // R17
            end else begin
                next_state.cnt = state.cnt + RATIO_W'(1);
            end
            next_state.div_clk = (next_state.cnt < half); // R17
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign div_clk = state.div_clk;

endmodule : ratio_divider

// ==== rtl/audio_clock_divider_and_clkout.sv ====
// Register file and divider bank for the audio clock dividers and clock output.
// ****************************************************************
// Overview of operation
// R1 - Second port low field; zero divides by 512
// R2 - Top second port code divides by 511
// R3 - Separate high bit extends second port ratio
// R4 - Auto detection replaces programmed ratio fields
// R5 - Analog ratio six bits; zero means 64
// R6 - N, M, PDM enables, reset off
// R7 - Modulator divider runs only when bit 4
// R8 - First port bit clock enable bit 3
// R9 - Second port bit clock enable bit 2
// R10 - First port frame enable bit 1
// R11 - Second port frame enable bit 0
// R12 - Three bit clock output source selector
// R13 - Software avoids reserved selector codes 6, 7
// R14 - Clock output enable bit 7, reset off
// R15 - Clock output ratio seven bits; zero 128
// R16 - Software writes reserved bits with reset values
// R17 - Output period equals ratio times source period
// R18 - Disabled divider holds low, clears count
// ****************************************************************
`timescale 1ns/1ps
`include "clkdiv_consts.svh"
module audio_clock_divider_and_clkout #(
    parameter int ADDR_W = 12,
    parameter int RATIO_W = 10
) (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sampled source clocks
    input wire logic pll_clk,
    input wire logic first_port_bitclk_in,
    input wire logic second_port_bitclk_in,
    input wire logic control_port_clock,
    input wire logic osc_clk,
    input wire logic dsp_clk,
    // Ratios held outside this block
    input wire logic [8:0] n_ratio,
    input wire logic [8:0] m_ratio,
    input wire logic [8:0] pulse_density_ratio,
    input wire logic [8:0] modulator_ratio,
    input wire logic [8:0] first_port_bitclk_ratio,
    input wire logic [8:0] first_port_frame_ratio,
    input wire logic [8:0] second_port_frame_ratio,
    // Ratios from the clock detector, used in automatic mode
    input wire logic [8:0] auto_second_bitclk_ratio,
    input wire logic [5:0] auto_analog_ratio,
    // Divided clocks
    output logic n_divider_clk,
    output logic m_divider_clk,
    output logic pulse_density_clk,
    output logic modulator_clk,
    output logic first_port_bitclk,
    output logic second_port_bitclk,
    output logic first_port_frame,
    output logic second_port_frame,
    output logic analog_divider_clk,
    output logic clock_output
);
    import clkdiv_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must cover the register map and fit 32 bits");
    end
    if (RATIO_W != 10) begin : g_bad_ratio
        $error("RATIO_W must be 10 to hold a ratio of 512");
    end

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic reg_sel_t decode_sel(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] idx;
        idx = addr >> 2;
        decode_sel = SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (idx)
                ADDR_W'(`IDX_SECOND_LOW): decode_sel = SEL_SECOND_LOW;
                ADDR_W'(`IDX_ANALOG_NM): decode_sel = SEL_ANALOG_NM;
                ADDR_W'(`IDX_CORE_EN): decode_sel = SEL_CORE_EN;
                ADDR_W'(`IDX_PORT_EN): decode_sel = SEL_PORT_EN;
                ADDR_W'(`IDX_CLKOUT_SRC): decode_sel = SEL_CLKOUT_SRC;
                ADDR_W'(`IDX_CLOCK_OUTPUT_RATIO): decode_sel = SEL_CLOCK_OUTPUT_RATIO;
                ADDR_W'(`IDX_SECOND_HIGH): decode_sel = SEL_SECOND_HIGH;
                ADDR_W'(`IDX_CONTROL): decode_sel = SEL_CONTROL;
                ADDR_W'(`IDX_STATUS): decode_sel = SEL_STATUS;
                default: decode_sel = SEL_NONE;
            endcase
        end
    endfunction : decode_sel

    // A zero code stands for the largest ratio of its field.
    function automatic logic [9:0] decode_ratio(input logic [8:0] code,
                                                input logic [9:0] zero_ratio);
        if (code == 9'h000) begin
            decode_ratio = zero_ratio;
        end else begin
            decode_ratio = {1'b0, code};
        end
    endfunction : decode_ratio

    // ****************************************************************
    // Register state
    // ****************************************************************
    regs_t state;
    regs_t next_state;
    reg_sel_t sel;
    logic access;
    logic commit;
    logic [RATIO_W-1:0] ratio [`NUM_DIVIDERS];
    logic enable [`NUM_DIVIDERS];
    logic source [`NUM_DIVIDERS];
    logic div_out [`NUM_DIVIDERS];
    logic [8:0] second_code;
    logic [5:0] analog_code;
    logic clkout_source;

    assign sel = decode_sel(paddr);
    // The answer comes one cycle into the access phase; the write lands on the next edge, which completes the transfer.
    assign access = psel && penable;
    assign commit = access && state.pready;

    // ****************************************************************
    // APB register file
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_state.pready = access && !state.pready;
        if (access && !state.pready) begin
            next_state.pslverr = (sel == SEL_NONE);
            next_state.prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (sel)
                    SEL_SECOND_LOW: begin
                        next_state.prdata[7:0] = state.second_low;
                    end
                    SEL_ANALOG_NM: begin
                        next_state.prdata[5:0] = state.analog_ratio;
                    end
                    SEL_CORE_EN: begin
                        next_state.prdata[2:0] = state.core_en;
                    end
                    SEL_PORT_EN: begin
                        next_state.prdata[7:0] = state.port_en;
                    end
                    SEL_CLKOUT_SRC: begin
                        next_state.prdata[2:0] = state.clkout_sel;
                    end
                    SEL_CLOCK_OUTPUT_RATIO: begin
                        next_state.prdata[7:0] = state.clock_output_ratio;
                    end
                    SEL_SECOND_HIGH: begin
                        next_state.prdata[0] = state.second_high;
                    end
                    SEL_CONTROL: begin
                        next_state.prdata[0] = state.auto_detect;
                    end
                    SEL_STATUS: begin
                        for (int i = 0; i < `NUM_DIVIDERS; i++) begin
                            next_state.prdata[i] = div_out[i];
                        end
                    end
                    default: begin
                        next_state.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end else if (!access) begin
            next_state.pslverr = 1'b0;
            next_state.prdata = 32'h0000_0000;
        end
        if (commit && pwrite) begin
            // Read-only reserved bits are not stored and always read as zero.
            case (sel)
                SEL_SECOND_LOW: begin
                    next_state.second_low = pwdata[7:0]; // R1
                end
                SEL_ANALOG_NM: begin
                    next_state.analog_ratio = pwdata[5:0]; // R5
                end
                SEL_CORE_EN: begin
                    next_state.core_en = pwdata[2:0]; // R6
                end
                SEL_PORT_EN: begin
                    // Upper reserved bits are kept as written; software keeps them zero.
                    next_state.port_en = pwdata[7:0]; // R16
                end
                SEL_CLKOUT_SRC: begin
                    next_state.clkout_sel = pwdata[2:0]; // R12
                end
                SEL_CLOCK_OUTPUT_RATIO: begin
                    next_state.clock_output_ratio = pwdata[7:0]; // R14
                end
                SEL_SECOND_HIGH: begin
                    next_state.second_high = pwdata[0]; // R3
                end
                SEL_CONTROL: begin
                    next_state.auto_detect = pwdata[0]; // R4
                end
                default: begin
                    next_state.auto_detect = state.auto_detect;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.second_low <= `RST_SECOND_LOW;
            state.second_high <= `RST_SECOND_HIGH;
            state.analog_ratio <= `RST_ANALOG_NM;
            state.core_en <= `RST_CORE_EN; // R6
            state.port_en <= `RST_PORT_EN; // R8
            state.clkout_sel <= `RST_CLKOUT_SRC;
            state.clock_output_ratio <= `RST_CLOCK_OUTPUT_RATIO; // R15
            state.auto_detect <= `RST_CONTROL;
            state.pready <= 1'b0;
            state.pslverr <= 1'b0;
            state.prdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;

    // ****************************************************************
    // Ratio selection
    // ****************************************************************
    always_comb begin
        if (state.auto_detect) begin
            // In automatic mode the programmed second port and analog ratio fields are ignored.
            second_code = auto_second_bitclk_ratio; // R4
            analog_code = auto_analog_ratio; // R4
        end else begin
            second_code = {state.second_high, state.second_low}; // R3
            analog_code = state.analog_ratio;
        end
    end

    // The selector reserves 6 and 7; they feed a quiet low source.
    always_comb begin
        case (state.clkout_sel)
            `SRC_PLL: clkout_source = pll_clk; // R12
            `SRC_FIRST_BCLK: clkout_source = first_port_bitclk_in;
            `SRC_SECOND_BCLK: clkout_source = second_port_bitclk_in;
            `SRC_CONTROL: clkout_source = control_port_clock;
            `SRC_OSC: clkout_source = osc_clk;
            `SRC_DSP: clkout_source = dsp_clk;
            default: clkout_source = 1'b0; // R13
        endcase
    end

    // ****************************************************************
    // Divider bank wiring
    // ****************************************************************
    // Index: 0 N, 1 M, 2 PDM, 3 modulator, 4 first bit clock,
    // 5 second bit clock, 6 first frame, 7 second frame, 8 analog, 9 output.
    always_comb begin
        ratio[0] = decode_ratio(n_ratio, `ZERO_RATIO_SECOND);
        ratio[1] = decode_ratio(m_ratio, `ZERO_RATIO_SECOND);
        ratio[2] = decode_ratio(pulse_density_ratio, `ZERO_RATIO_SECOND);
        ratio[3] = decode_ratio(modulator_ratio, `ZERO_RATIO_SECOND);
        ratio[4] = decode_ratio(first_port_bitclk_ratio, `ZERO_RATIO_SECOND);
        ratio[5] = decode_ratio(second_code, `ZERO_RATIO_SECOND); // R1 R2
        ratio[6] = decode_ratio(first_port_frame_ratio, `ZERO_RATIO_SECOND);
        ratio[7] = decode_ratio(second_port_frame_ratio, `ZERO_RATIO_SECOND);
        ratio[8] = decode_ratio({3'h0, analog_code}, `ZERO_RATIO_ANALOG); // R5
        ratio[9] = decode_ratio({2'h0, state.clock_output_ratio[`MSB_CLKOUT_RATIO:0]},
                                `ZERO_RATIO_CLKOUT); // R15
    end

    always_comb begin
        enable[0] = state.core_en[`BIT_N_EN]; // R6
        enable[1] = state.core_en[`BIT_M_EN]; // R6
        enable[2] = state.core_en[`BIT_PDM_EN]; // R6
        enable[3] = state.port_en[`BIT_MOD_EN]; // R7
        enable[4] = state.port_en[`BIT_FIRST_BCLK_EN]; // R8
        enable[5] = state.port_en[`BIT_SECOND_BCLK_EN]; // R9
        enable[6] = state.port_en[`BIT_FIRST_FS_EN]; // R10
        enable[7] = state.port_en[`BIT_SECOND_FS_EN]; // R11
        // The analog divider needs both the N and M dividers running.
        enable[8] = state.core_en[`BIT_N_EN] && state.core_en[`BIT_M_EN];
        enable[9] = state.clock_output_ratio[`BIT_CLKOUT_EN]; // R14
    end

    // Frame dividers count the divided bit clocks of their own port.
    always_comb begin
        source[0] = pll_clk;
        source[1] = pll_clk;
        source[2] = dsp_clk;
        source[3] = dsp_clk;
        source[4] = dsp_clk;
        source[5] = dsp_clk;
        source[6] = div_out[4];
        source[7] = div_out[5];
        source[8] = pll_clk;
        source[9] = clkout_source;
    end

    // ****************************************************************
    // Divider bank
    // ****************************************************************
    for (genvar g = 0; g < `NUM_DIVIDERS; g++) begin : gen_div
        ratio_divider #(
            .RATIO_W(RATIO_W)
        ) u_div (
            .pclk(pclk),
            .presetn(presetn),
            .enable(enable[g]),
            .ratio(ratio[g]),
            .source(source[g]),
            .div_clk(div_out[g])
        );
    end

    assign n_divider_clk = div_out[0];
    assign m_divider_clk = div_out[1];
    assign pulse_density_clk = div_out[2];
    assign modulator_clk = div_out[3];
    assign first_port_bitclk = div_out[4];
    assign second_port_bitclk = div_out[5];
    assign first_port_frame = div_out[6];
    assign second_port_frame = div_out[7];
    assign analog_divider_clk = div_out[8];
    assign clock_output = div_out[9];

endmodule : audio_clock_divider_and_clkout

// ==== tb/audio_clock_divider_and_clkout_monitor.sv ====
// Checker that ties each divided clock except the analog one to its enable bit as last written over APB.
`timescale 1ns/1ps
`include "clkdiv_consts.svh"
module audio_clock_divider_and_clkout_monitor #(
    parameter int ADDR_W = 12
) (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Divided clocks
    input wire logic n_divider_clk,
    input wire logic m_divider_clk,
    input wire logic pulse_density_clk,
    input wire logic modulator_clk,
    input wire logic first_port_bitclk,
    input wire logic second_port_bitclk,
    input wire logic first_port_frame,
    input wire logic second_port_frame,
    input wire logic clock_output
);
    // ********
    // Shadow of the enable bits
    // ********
    logic done;
    logic [2:0] core_en;
    logic [7:0] port_en;
    logic clkout_en;
    assign done = psel && penable && pready && pwrite && !pslverr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_en <= 3'h0;
            port_en <= 8'h00;
            clkout_en <= 1'b0;
        end else if (done) begin
            if ((paddr >> 2) == ADDR_W'(`IDX_CORE_EN)) core_en <= pwdata[2:0];
            if ((paddr >> 2) == ADDR_W'(`IDX_PORT_EN)) port_en <= pwdata[7:0];
            if ((paddr >> 2) == ADDR_W'(`IDX_CLOCK_OUTPUT_RATIO)) clkout_en <= pwdata[7];
        end
    end
    // ********
    // A divider is low once its enable has been clear for two edges, or for three cycles after the fall for PDM and second bit clock
    // ********
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_n_off; (!core_en[2]) [*2] |-> !n_divider_clk; endproperty
    a_n_off: assert property (p_n_off) else $error("N divider runs while disabled");
    property p_m_off; !core_en[1] && !$past(core_en[1]) |-> !m_divider_clk; endproperty
    a_m_off: assert property (p_m_off) else $error("M divider runs while disabled");
    property p_pdm_off; $fell(core_en[0]) |=> (!pulse_density_clk) [*3]; endproperty
    a_pdm_off: assert property (p_pdm_off) else $error("PDM divider runs after disable");
    property p_mod_off; !port_en[4] && !$past(port_en[4]) |-> !modulator_clk; endproperty
    a_mod_off: assert property (p_mod_off) else $error("Modulator divider runs");
    property p_fb_off; (!port_en[3]) [*2] |-> !first_port_bitclk; endproperty
    a_fb_off: assert property (p_fb_off) else $error("First bit clock runs");
    property p_sb_off; $fell(port_en[2]) |=> (!second_port_bitclk) [*3]; endproperty
    a_sb_off: assert property (p_sb_off) else $error("Second bit clock runs");
    property p_ff_off; !port_en[1] && !$past(port_en[1]) |-> !first_port_frame; endproperty
    a_ff_off: assert property (p_ff_off) else $error("First frame clock runs");
    property p_sf_off; (!port_en[0]) [*2] |-> !second_port_frame; endproperty
    a_sf_off: assert property (p_sf_off) else $error("Second frame clock runs");
    property p_co_off; !clkout_en && !$past(clkout_en) |-> !clock_output; endproperty
    a_co_off: assert property (p_co_off) else $error("Clock output runs while disabled");
    c_err: cover property (pready && pslverr);
    c_co_run: cover property (clkout_en && clock_output);
    c_sb_run: cover property (port_en[2] && second_port_bitclk);
endmodule : audio_clock_divider_and_clkout_monitor

bind audio_clock_divider_and_clkout audio_clock_divider_and_clkout_monitor #(
    .ADDR_W(ADDR_W)
) u_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .n_divider_clk(n_divider_clk), .m_divider_clk(m_divider_clk),
    .pulse_density_clk(pulse_density_clk), .modulator_clk(modulator_clk),
    .first_port_bitclk(first_port_bitclk), .second_port_bitclk(second_port_bitclk),
    .first_port_frame(first_port_frame), .second_port_frame(second_port_frame),
    .clock_output(clock_output)
);

// ==== tb/tb_audio_clock_divider_and_clkout.sv ====
// Self-checking bench for the audio clock divider and clock output block.
`timescale 1ns/1ps
module tb_audio_clock_divider_and_clkout;
    typedef struct {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] src = 6'h00;
    logic [8:0] ratio = 9'h002;
    logic [8:0] auto_sb = 9'h003;
    logic [5:0] auto_an = 6'h05;
    logic [9:0] outs;
    int src_cnt = 0;
    int mismatches = 0;
    int n_checks = 0;
    row_t rows [6] = '{'{12'h0F4, 32'hA5, 32'hA5}, '{12'h0F8, 32'h3F, 32'h3F},
        '{12'h110, 32'h07, 32'h07}, '{12'h114, 32'h1F, 32'h1F},
        '{12'h118, 32'h05, 32'h05}, '{12'h11C, 32'h85, 32'h85}};
    logic [31:0] rst_exp [6] = '{32'h01, 32'h01, 32'h00, 32'h00, 32'h00, 32'h01};
    int per [9] = '{28, 28, 8, 8, 8, 8, 16, 16, 28};
    int co [3] = '{3, 127, 0};
    logic [8:0] sb [3] = '{9'h000, 9'h1FF, 9'h100};

    always #2.5 pclk = ~pclk;
    // Every source has its own period, 14 down to 4 cycles, so a wrong select shows.
    always @(posedge pclk) begin
        src_cnt <= src_cnt + 1;
        for (int i = 0; i < 6; i++) begin
            src[i] <= (src_cnt % (14 - 2 * i)) < (7 - i);
        end
    end

    audio_clock_divider_and_clkout u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_clk(src[0]), .first_port_bitclk_in(src[1]), .second_port_bitclk_in(src[2]),
        .control_port_clock(src[3]), .osc_clk(src[4]), .dsp_clk(src[5]),
        .n_ratio(ratio), .m_ratio(ratio), .pulse_density_ratio(ratio), .modulator_ratio(ratio),
        .first_port_bitclk_ratio(ratio), .first_port_frame_ratio(ratio),
        .second_port_frame_ratio(ratio), .auto_second_bitclk_ratio(auto_sb),
        .auto_analog_ratio(auto_an), .n_divider_clk(outs[0]), .m_divider_clk(outs[1]),
        .pulse_density_clk(outs[2]), .modulator_clk(outs[3]), .first_port_bitclk(outs[4]),
        .second_port_bitclk(outs[5]), .first_port_frame(outs[6]),
        .second_port_frame(outs[7]), .analog_divider_clk(outs[8]), .clock_output(outs[9])
    );

    // ********
    // Shared tasks
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask : rdchk

    task automatic till(input int idx, input logic lvl, inout int k);
        while (outs[idx] !== lvl && k < 9000) begin
            @(posedge pclk);
            k++;
        end
    endtask : till

    // The first period after a change may be short, so two rises are skipped.
    task automatic period(input int idx, input int exp);
        int k;
        k = 0;
        for (int i = 0; i < 3; i++) begin
            if (i == 2) k = 0;
            till(idx, 1'b0, k);
            till(idx, 1'b1, k);
        end
        check(32'(k), 32'(exp));
    endtask : period

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // ********
    // Main sequence
    // ********
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].rdata, 1'b0);
        end
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        check({22'h0, outs}, 32'h0);
        presetn <= 1'b1;
        foreach (rows[i]) rdchk(rows[i].addr, rst_exp[i], 1'b0);
        rdchk(12'h0FC, 32'h0, 1'b1);
        rdchk(12'h188, 32'h0, 1'b0);
        wr(12'h0F4, 32'h02);
        wr(12'h0F8, 32'h02);
        wr(12'h110, 32'h07);
        wr(12'h114, 32'h1F);
        foreach (per[i]) period(i, per[i]);
        wr(12'h11C, 32'h81);
        for (int c = 0; c < 6; c++) begin
            wr(12'h118, 32'(c));
            period(9, 14 - 2 * c);
        end
        foreach (co[i]) begin
            wr(12'h11C, 32'h80 | 32'(co[i]));
            period(9, 4 * ((co[i] == 0) ? 128 : co[i]));
        end
        foreach (sb[i]) begin
            wr(12'h180, {31'h0, sb[i][8]});
            wr(12'h0F4, {24'h0, sb[i][7:0]});
            period(5, 4 * ((sb[i] == 9'h000) ? 512 : int'(sb[i])));
        end
        wr(12'h0F8, 32'h00);
        period(8, 896);
        wr(12'h184, 32'h01);
        period(5, 12);
        period(8, 70);
        wr(12'h11C, 32'h05);
        wr(12'h110, 32'h00);
        wr(12'h114, 32'h00);
        repeat (40) @(posedge pclk);
        check({22'h0, outs}, 32'h0);
        final_report();
    end

    initial begin
        #400000;
        mismatches++;
        final_report();
    end
endmodule : tb_audio_clock_divider_and_clkout
